// ---- shared/tocp_map.vh ----
// Register offsets, field positions, reset values and codes of the timer.
`ifndef TOCP_MAP_VH
`define TOCP_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TOCP_OFS_CTRL_ONE 8'h00
`define TOCP_OFS_CTRL_TWO 8'h04
`define TOCP_OFS_STATUS 8'h08
`define TOCP_OFS_COUNT 8'h0C
`define TOCP_OFS_CMP1_HI 8'h10
`define TOCP_OFS_CMP1_LO 8'h14
`define TOCP_OFS_CMP2_HI 8'h18
`define TOCP_OFS_CMP2_LO 8'h1C
`define TOCP_OFS_CAP1_HI 8'h20
`define TOCP_OFS_CAP1_LO 8'h24
// ----------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------
`define TOCP_C1_CAP_IE 7
`define TOCP_C1_CMP_IE 6
`define TOCP_C1_OVF_IE 5
`define TOCP_C1_FORCE2 4
`define TOCP_C1_FORCE1 3
`define TOCP_C1_LEVEL2 2
`define TOCP_C1_EDGE1 1
`define TOCP_C1_LEVEL1 0
// ----------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------
`define TOCP_C2_PIN_EN1 7
`define TOCP_C2_PIN_EN2 6
`define TOCP_C2_ONE_PULSE 5
`define TOCP_C2_PWM 4
`define TOCP_C2_CLK_HI 3
`define TOCP_C2_CLK_LO 2
`define TOCP_C2_EXT_EDGE 0
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define TOCP_SR_CAP1 7
`define TOCP_SR_CMP1 6
`define TOCP_SR_CMP2 5
`define TOCP_SR_OVF 4
// ----------------------------------------------------------------
// Clock select codes, reset and load values
// ----------------------------------------------------------------
`define TOCP_CLK_DIV4 2'h0
`define TOCP_CLK_DIV2 2'h1
`define TOCP_CLK_DIV8 2'h2
`define TOCP_CLK_EXT 2'h3
`define TOCP_CMP_RESET 16'h8000
`define TOCP_CNT_RELOAD 16'hFFFC
`define TOCP_CAP_PULSE 16'hFFFD
`define TOCP_CTRL_RESET 8'h00
`endif

// ---- rtl/tocp_top.v ----
// Timer output compare, one-pulse and PWM section with an APB slave.
// Overview of operation
// - Match sets channel flag, drives pin level if enabled, may interrupt.
// - Each 16-bit compare value is checked against the counter every tick.
// - Compare values are software read/write only; reset loads 8000h.
// - Compare pin latches are held low during reset.
// - Flag clears after status read with flag set, then low byte access (counter access for overflow).
// - High byte write suspends compare until the low byte is written.
// - With pin disabled, match sets flag but leaves the pin alone.
// - Divide-by-2 matches counter equal; other clocks match value plus 1.
// - Force with pin enabled copies level to pin without flag or irq.
// - Force bits are ignored in one-pulse or PWM mode.
// - Timer tick is CPU clock over 2, 4, 8, or an external clock.
// - One-pulse mode bit uses trigger one and compare channel one.
// - One-pulse trigger reloads FFFCh, pin one gets level two, capture FFFDh.
// - One-pulse compare one match drives pin one with level one.
// - One-pulse mode never sets compare flag one; flag two still works.
// - With both mode bits set only PWM mode operates.
// - One-pulse trigger does no ordinary capture; capture flag still irqs.
// - One-pulse channel two still flags but never drives its own pin.
// - PWM compare values are double-buffered, loaded at channel two match.
// - PWM match one drives level one, match two level two on pin one.
// - PWM channel two match reloads the counter with FFFCh.
// - PWM sets no compare flags; period end sets capture flag one.
// - Clock select value three picks the external timer clock.
`timescale 1ns/10ps
`include "tocp_map.vh"

module tocp_top (
    // Clock and reset
    input wire I_CLK,
    input wire I_RST,
    // APB slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    // Pins
    input wire I_TRIGGER_INPUT_ONE,
    input wire I_EXT_CLK,
    output wire O_COMPARE_OUTPUT_PIN_ONE,
    output wire O_COMPARE_OUTPUT_PIN_ONE_OE,
    output wire O_COMPARE_OUTPUT_PIN_TWO,
    output wire O_COMPARE_OUTPUT_PIN_TWO_OE,
    // CPU interrupt
    input wire I_CPU_IRQ_MASK,
    output wire O_TIMER_IRQ
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] ctrl_one_ff;
    reg [7:0] ctrl_two_ff;
    reg [15:0] sw_cmp1_ff;
    reg [15:0] sw_cmp2_ff;
    reg [15:0] act_cmp1_ff;
    reg [15:0] act_cmp2_ff;
    reg inhibit1_ff;
    reg inhibit2_ff;
    reg [15:0] counter_ff;
    reg [15:0] capture_one_ff;
    reg [2:0] presc_ff;
    reg cap1_flag_ff;
    reg cmp1_flag_ff;
    reg cmp2_flag_ff;
    reg ovf_flag_ff;
    reg [3:0] arm_ff;
    reg pin1_ff;
    reg pin2_ff;
    reg trig_s1_ff;
    reg trig_s2_ff;
    reg trig_s3_ff;
    reg ext_s1_ff;
    reg ext_s2_ff;
    reg ext_s3_ff;
    reg ready_ff;
    reg slverr_ff;
    reg [31:0] prdata_ff;
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Each register except the 16-bit counter is one byte at bits 7:0 of an aligned word.
    wire acc = I_PSEL & I_PENABLE & ready_ff;
    wire wr = acc & I_PWRITE;
    wire rd = acc & ~I_PWRITE;
    wire hit_cmp1_hi = I_PADDR == `TOCP_OFS_CMP1_HI;
    wire hit_cmp1_lo = I_PADDR == `TOCP_OFS_CMP1_LO;
    wire hit_cmp2_hi = I_PADDR == `TOCP_OFS_CMP2_HI;
    wire hit_cmp2_lo = I_PADDR == `TOCP_OFS_CMP2_LO;
    wire hit_count = I_PADDR == `TOCP_OFS_COUNT;
    wire hit_cap1_lo = I_PADDR == `TOCP_OFS_CAP1_LO;
    wire status_rd = rd & (I_PADDR == `TOCP_OFS_STATUS);
    reg [31:0] rdata;
    reg mapped;
    always @* begin
        rdata = 32'h0000_0000;
        mapped = 1'b1;
        if (I_PADDR == `TOCP_OFS_CTRL_ONE) begin
            rdata[7:0] = ctrl_one_ff;
        end else if (I_PADDR == `TOCP_OFS_CTRL_TWO) begin
            rdata[7:0] = ctrl_two_ff;
        end else if (I_PADDR == `TOCP_OFS_STATUS) begin
            rdata[`TOCP_SR_CAP1] = cap1_flag_ff;
            rdata[`TOCP_SR_CMP1] = cmp1_flag_ff;
            rdata[`TOCP_SR_CMP2] = cmp2_flag_ff;
            rdata[`TOCP_SR_OVF] = ovf_flag_ff;
        end else if (hit_count) begin
            rdata[15:0] = counter_ff;
        end else if (hit_cmp1_hi) begin
            rdata[7:0] = sw_cmp1_ff[15:8];
        end else if (hit_cmp1_lo) begin
            rdata[7:0] = sw_cmp1_ff[7:0];
        end else if (hit_cmp2_hi) begin
            rdata[7:0] = sw_cmp2_ff[15:8];
        end else if (hit_cmp2_lo) begin
            rdata[7:0] = sw_cmp2_ff[7:0];
        end else if (I_PADDR == `TOCP_OFS_CAP1_HI) begin
            rdata[7:0] = capture_one_ff[15:8];
        end else if (hit_cap1_lo) begin
            rdata[7:0] = capture_one_ff[7:0];
        end else begin
            mapped = 1'b0;
        end
    end

    // One wait state: data and ready come from flip-flops.
    // A refused address answers with an error and zero data.
    always @(posedge I_CLK) begin
        if (I_RST) begin
            ready_ff <= 1'b0;
            slverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ready_ff <= I_PSEL & I_PENABLE & ~ready_ff;
            slverr_ff <= I_PSEL & I_PENABLE & ~ready_ff & ~mapped;
            if (I_PSEL & I_PENABLE & ~ready_ff) begin
                prdata_ff <= I_PWRITE ? 32'h0000_0000 : rdata;
            end
        end
    end
    assign O_PREADY = ready_ff;
    assign O_PSLVERR = slverr_ff;
    assign O_PRDATA = prdata_ff;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Setting both mode bits selects PWM only.
    wire pwm = ctrl_two_ff[`TOCP_C2_PWM];
    wire one_pulse_select = ctrl_two_ff[`TOCP_C2_ONE_PULSE] & ~pwm;
    wire pin_en1 = ctrl_two_ff[`TOCP_C2_PIN_EN1];
    wire pin_en2 = ctrl_two_ff[`TOCP_C2_PIN_EN2];
    wire [1:0] clk_sel = ctrl_two_ff[`TOCP_C2_CLK_HI:`TOCP_C2_CLK_LO];
    wire level1 = ctrl_one_ff[`TOCP_C1_LEVEL1];
    wire level2 = ctrl_one_ff[`TOCP_C1_LEVEL2];

    // ----------------------------------------------------------------
    // Pin synchronisers and tick
    // ----------------------------------------------------------------
    // The synchronisers run through reset, so a pin resting high gives
    // no false edge once reset is released.
    always @(posedge I_CLK) begin
        trig_s1_ff <= I_TRIGGER_INPUT_ONE;
        trig_s2_ff <= trig_s1_ff;
        trig_s3_ff <= trig_s2_ff;
        ext_s1_ff <= I_EXT_CLK;
        ext_s2_ff <= ext_s1_ff;
        ext_s3_ff <= ext_s2_ff;
        if (I_RST) begin
            presc_ff <= 3'h0;
        end else begin
            presc_ff <= presc_ff + 3'h1;
        end
    end
    wire trig_rise = trig_s2_ff & ~trig_s3_ff;
    wire trig_fall = ~trig_s2_ff & trig_s3_ff;
    wire trig_edge = ctrl_one_ff[`TOCP_C1_EDGE1] ? trig_rise : trig_fall;
    wire ext_rise = ext_s2_ff & ~ext_s3_ff;
    wire ext_fall = ~ext_s2_ff & ext_s3_ff;
    wire ext_edge = ctrl_two_ff[`TOCP_C2_EXT_EDGE] ? ext_rise : ext_fall;
    // One-cycle tick enable from the prescaler or the external edge.
    reg tick;
    always @* begin
        if (clk_sel == `TOCP_CLK_DIV2) begin
            tick = presc_ff[0];
        end else if (clk_sel == `TOCP_CLK_DIV4) begin
            tick = &presc_ff[1:0];
        end else if (clk_sel == `TOCP_CLK_DIV8) begin
            tick = &presc_ff;
        end else begin
            tick = ext_edge;
        end
    end

    // ----------------------------------------------------------------
    // Compare
    // ----------------------------------------------------------------
    // Slower clocks see the match one count later than divide-by-2.
    wire fast = clk_sel == `TOCP_CLK_DIV2;
    wire [15:0] tgt1 = fast ? act_cmp1_ff : act_cmp1_ff + 16'h0001;
    wire [15:0] tgt2 = fast ? act_cmp2_ff : act_cmp2_ff + 16'h0001;
    // A high byte write holds the channel off until its low byte arrives.
    wire eq1 = (counter_ff == tgt1) & ~inhibit1_ff;
    wire eq2 = (counter_ff == tgt2) & ~inhibit2_ff;
    // A PWM period ends on the tick at which channel two matches.
    wire pwm_end = pwm & eq2 & tick;
    wire opm_trig = one_pulse_select & trig_edge;
    wire cap_edge = ~one_pulse_select & ~pwm & trig_edge;

    // Software copies; never written by the timer itself.
    always @(posedge I_CLK) begin
        if (I_RST) begin
            sw_cmp1_ff <= `TOCP_CMP_RESET;
            sw_cmp2_ff <= `TOCP_CMP_RESET;
            inhibit1_ff <= 1'b0;
            inhibit2_ff <= 1'b0;
            ctrl_one_ff <= `TOCP_CTRL_RESET;
            ctrl_two_ff <= `TOCP_CTRL_RESET;
        end else if (wr) begin
            if (I_PADDR == `TOCP_OFS_CTRL_ONE) begin
                ctrl_one_ff <= I_PWDATA[7:0];
            end else if (I_PADDR == `TOCP_OFS_CTRL_TWO) begin
                ctrl_two_ff <= I_PWDATA[7:0];
            end else if (hit_cmp1_hi) begin
                sw_cmp1_ff[15:8] <= I_PWDATA[7:0];
                inhibit1_ff <= 1'b1;
            end else if (hit_cmp1_lo) begin
                sw_cmp1_ff[7:0] <= I_PWDATA[7:0];
                inhibit1_ff <= 1'b0;
            end else if (hit_cmp2_hi) begin
                sw_cmp2_ff[15:8] <= I_PWDATA[7:0];
                inhibit2_ff <= 1'b1;
            end else if (hit_cmp2_lo) begin
                sw_cmp2_ff[7:0] <= I_PWDATA[7:0];
                inhibit2_ff <= 1'b0;
            end
        end
    end

    // Active values follow software except in PWM mode.
    // In PWM they load only at a period end, so the output never spikes.
    always @(posedge I_CLK) begin
        if (I_RST) begin
            act_cmp1_ff <= `TOCP_CMP_RESET;
            act_cmp2_ff <= `TOCP_CMP_RESET;
        end else if (~pwm | pwm_end) begin
            act_cmp1_ff <= sw_cmp1_ff;
            act_cmp2_ff <= sw_cmp2_ff;
        end
    end

    // ----------------------------------------------------------------
    // Counter and capture one
    // ----------------------------------------------------------------
    // A counter write, a one-pulse trigger and a period end all reload.
    wire cnt_access = acc & hit_count;
    always @(posedge I_CLK) begin
        if (I_RST) begin
            counter_ff <= `TOCP_CNT_RELOAD;
        end else if ((wr & hit_count) | opm_trig) begin
            counter_ff <= `TOCP_CNT_RELOAD;
        end else if (pwm_end) begin
            counter_ff <= `TOCP_CNT_RELOAD;
        end else if (tick) begin
            counter_ff <= counter_ff + 16'h0001;
        end
    end
    wire ovf_set = tick & (counter_ff == 16'hFFFF) & ~cnt_access &
        ~opm_trig & ~pwm_end;

    // In one-pulse mode the trigger loads a fixed value, not the count.
    always @(posedge I_CLK) begin
        if (I_RST) begin
            capture_one_ff <= 16'h0000;
        end else if (opm_trig) begin
            capture_one_ff <= `TOCP_CAP_PULSE;
        end else if (cap_edge) begin
            capture_one_ff <= counter_ff;
        end
    end

    // ----------------------------------------------------------------
    // Flags and the two-step clear
    // ----------------------------------------------------------------
    // Matching is level based: a flag is set again each cycle the match
    // holds, and a set in the same cycle as a clear wins.
    wire set_cap1 = cap_edge | opm_trig | pwm_end;
    wire set_cmp1 = eq1 & ~pwm & ~one_pulse_select;
    wire set_cmp2 = eq2 & ~pwm;
    wire clr_cap1 = arm_ff[3] & acc & hit_cap1_lo;
    wire clr_cmp1 = arm_ff[2] & acc & hit_cmp1_lo;
    wire clr_cmp2 = arm_ff[1] & acc & hit_cmp2_lo;
    wire clr_ovf = arm_ff[0] & cnt_access;
    always @(posedge I_CLK) begin
        if (I_RST) begin
            cap1_flag_ff <= 1'b0;
            cmp1_flag_ff <= 1'b0;
            cmp2_flag_ff <= 1'b0;
            ovf_flag_ff <= 1'b0;
            arm_ff <= 4'h0;
        end else begin
            cap1_flag_ff <= set_cap1 | (cap1_flag_ff & ~clr_cap1);
            cmp1_flag_ff <= set_cmp1 | (cmp1_flag_ff & ~clr_cmp1);
            cmp2_flag_ff <= set_cmp2 | (cmp2_flag_ff & ~clr_cmp2);
            ovf_flag_ff <= ovf_set | (ovf_flag_ff & ~clr_ovf);
            // Arm only the flags that the status word read back showed,
            // so a flag set during the read is never cleared unseen.
            if (status_rd) begin
                arm_ff <= {prdata_ff[`TOCP_SR_CAP1],
                    prdata_ff[`TOCP_SR_CMP1], prdata_ff[`TOCP_SR_CMP2],
                    prdata_ff[`TOCP_SR_OVF]};
            end else begin
                arm_ff <= arm_ff & ~{clr_cap1, clr_cmp1, clr_cmp2, clr_ovf};
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin latches
    // ----------------------------------------------------------------
    // When both PWM matches fall together the period end wins.
    // In one-pulse and PWM mode the latch moves even with its pin off.
    reg nxt_pin1;
    reg nxt_pin2;
    always @* begin
        nxt_pin1 = pin1_ff;
        nxt_pin2 = pin2_ff;
        if (pwm) begin
            if (eq2) begin
                nxt_pin1 = level2;
            end else if (eq1) begin
                nxt_pin1 = level1;
            end
        end else if (one_pulse_select) begin
            if (opm_trig) begin
                nxt_pin1 = level2;
            end else if (eq1) begin
                nxt_pin1 = level1;
            end
        end else begin
            if (pin_en1 & (eq1 | ctrl_one_ff[`TOCP_C1_FORCE1])) begin
                nxt_pin1 = level1;
            end
            if (pin_en2 & (eq2 | ctrl_one_ff[`TOCP_C1_FORCE2])) begin
                nxt_pin2 = level2;
            end
        end
    end
    always @(posedge I_CLK) begin
        if (I_RST) begin
            pin1_ff <= 1'b0;
            pin2_ff <= 1'b0;
        end else begin
            pin1_ff <= nxt_pin1;
            pin2_ff <= nxt_pin2;
        end
    end
    assign O_COMPARE_OUTPUT_PIN_ONE = pin1_ff;
    assign O_COMPARE_OUTPUT_PIN_ONE_OE = pin_en1;
    assign O_COMPARE_OUTPUT_PIN_TWO = pin2_ff;
    // Pin two is left to general I/O while its level serves the pulse.
    assign O_COMPARE_OUTPUT_PIN_TWO_OE = pin_en2 & ~one_pulse_select & ~pwm;

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    // All enabled flags share one request, blocked while the mask is set.
    assign O_TIMER_IRQ = ~I_CPU_IRQ_MASK & (
        (ctrl_one_ff[`TOCP_C1_CAP_IE] & cap1_flag_ff) |
        (ctrl_one_ff[`TOCP_C1_CMP_IE] & (cmp1_flag_ff | cmp2_flag_ff)) |
        (ctrl_one_ff[`TOCP_C1_OVF_IE] & ovf_flag_ff));
endmodule // tocp_top

// ---- testbench/tocp_checker_properties.sv ----
// Port-level assertions for the timer compare, one-pulse and PWM block.
`timescale 1ns/10ps
`include "tocp_map.vh"
module tocp_checker (
    // Clock, reset and register bus
    input wire I_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    // Pins and interrupt
    input wire O_COMPARE_OUTPUT_PIN_ONE,
    input wire O_COMPARE_OUTPUT_PIN_ONE_OE,
    input wire O_COMPARE_OUTPUT_PIN_TWO,
    input wire O_COMPARE_OUTPUT_PIN_TWO_OE,
    input wire I_CPU_IRQ_MASK,
    input wire O_TIMER_IRQ
);
    logic [7:0] ctl1_ff;
    logic [7:0] ctl2_ff;
    wire wr_done = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    wire pin1 = O_COMPARE_OUTPUT_PIN_ONE;
    wire pin2 = O_COMPARE_OUTPUT_PIN_TWO;
    // Shadow copies of both control registers, taken at write completion.
    always @(posedge I_CLK) begin
        if (I_RST) begin
            ctl1_ff <= 8'h00;
            ctl2_ff <= 8'h00;
        end else if (wr_done && I_PADDR == `TOCP_OFS_CTRL_ONE) begin
            ctl1_ff <= I_PWDATA[7:0];
        end else if (wr_done && I_PADDR == `TOCP_OFS_CTRL_TWO) begin
            ctl2_ff <= I_PWDATA[7:0];
        end
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_wait;
        I_PSEL && I_PENABLE && !O_PREADY;
    endsequence
    sequence s_forced;
        ctl1_ff[3] && ctl2_ff[7] && ctl2_ff[5:4] == 2'h0 && $stable(ctl1_ff);
    endsequence
    apb_wait_a: assert property (s_setup |=> s_wait ##1 O_PREADY)
        else $error("bus answer not after one wait cycle");
    bad_addr_a: assert property (O_PREADY && I_PADDR > 8'h24 |->
        O_PSLVERR && O_PRDATA == 32'h0)
        else $error("unmapped access not refused");
    pin_reset_a: assert property (disable iff (1'b0) I_RST |=>
        !pin1 && !pin2 && !O_COMPARE_OUTPUT_PIN_ONE_OE)
        else $error("pin latch not low in reset");
    oe_one_a: assert property (O_COMPARE_OUTPUT_PIN_ONE_OE == ctl2_ff[7])
        else $error("pin one enable wrong");
    oe_two_a: assert property (O_COMPARE_OUTPUT_PIN_TWO_OE ==
        (ctl2_ff[6] && ctl2_ff[5:4] == 2'h0))
        else $error("pin two enable wrong");
    pin_idle_a: assert property (!ctl2_ff[7] && ctl2_ff[5:4] == 2'h0
        |=> $stable(pin1))
        else $error("disabled pin changed");
    irq_mask_a: assert property (I_CPU_IRQ_MASK |-> !O_TIMER_IRQ)
        else $error("irq raised while masked");
    irq_off_a: assert property (ctl1_ff[7:5] == 3'h0 |-> !O_TIMER_IRQ)
        else $error("irq raised with no enable");
    force_pin_a: assert property (s_forced [*3] |-> pin1 == ctl1_ff[0])
        else $error("forced level not on pin");
endmodule // tocp_checker
bind tocp_top tocp_checker u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_COMPARE_OUTPUT_PIN_ONE(O_COMPARE_OUTPUT_PIN_ONE),
    .O_COMPARE_OUTPUT_PIN_ONE_OE(O_COMPARE_OUTPUT_PIN_ONE_OE),
    .O_COMPARE_OUTPUT_PIN_TWO(O_COMPARE_OUTPUT_PIN_TWO),
    .O_COMPARE_OUTPUT_PIN_TWO_OE(O_COMPARE_OUTPUT_PIN_TWO_OE),
    .I_CPU_IRQ_MASK(I_CPU_IRQ_MASK), .O_TIMER_IRQ(O_TIMER_IRQ));

// ---- testbench/tocp_pin_model.sv ----
// Pin-side model: external timer clock and trigger source.
`timescale 1ns/10ps
module tocp_pin_model (
    // Control from the bench
    input wire logic i_clk,
    input wire logic i_ext_on,
    input wire logic i_fire,
    // Pins toward the timer
    output logic o_ext_clk,
    output logic o_trigger
);
    logic [1:0] div_ff = 2'h0;
    initial o_ext_clk = 1'b0;
    // Toggles every fourth clock so active edges stay far apart.
    always @(posedge i_clk) begin
        div_ff <= div_ff + 2'h1;
        if (i_ext_on && div_ff == 2'h3) begin
            o_ext_clk <= ~o_ext_clk;
        end
    end
    assign o_trigger = i_fire;
endmodule // tocp_pin_model

// ---- testbench/test_timer_output_compare_pwm.sv ----
// Self-checking bench for the timer compare, one-pulse and PWM block.
`timescale 1ns/10ps
`include "tocp_map.vh"
module test_timer_output_compare_pwm;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic mask = 1'b0, ext_on = 1'b0, fire = 1'b0, rerr, exp_pin = 1'b0;
    logic [7:0] paddr = 8'h00, rdat;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, trig, ext_clk, pin1, oe1, pin2, oe2, irq;
    int bad_count = 0, n_checks = 0, cyc = 0, seed = 71437;
    logic [7:0] exp_q[$] = '{8'h80, 8'h00, 8'h80, 8'h00};
    always #20 clk = ~clk;
    tocp_top dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_TRIGGER_INPUT_ONE(trig), .I_EXT_CLK(ext_clk),
        .O_COMPARE_OUTPUT_PIN_ONE(pin1), .O_COMPARE_OUTPUT_PIN_ONE_OE(oe1),
        .O_COMPARE_OUTPUT_PIN_TWO(pin2), .O_COMPARE_OUTPUT_PIN_TWO_OE(oe2),
        .I_CPU_IRQ_MASK(mask), .O_TIMER_IRQ(irq));
    tocp_pin_model pins (.i_clk(clk), .i_ext_on(ext_on), .i_fire(fire),
        .o_ext_clk(ext_clk), .o_trigger(trig));
    function automatic int lfsr(input int s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bad(input string m);
        bad_count++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk_rd(input [7:0] got, input [7:0] exp);
        n_checks++;
        if (got !== exp) bad($sformatf("read %h want %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) bad($sformatf("bit %b want %b", got, exp));
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input [7:0] a, input [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] e, input [7:0] m = 8'hFF);
        apb(1'b0, a, 8'h00);
        chk_rd(rdat & m, e);
    endtask
    task automatic wt(input logic sel, input logic v, input int n);
        for (int i = 0; i < n && (sel ? irq : pin1) !== v; i++)
            @(posedge clk);
        chk_bit(sel ? irq : pin1, v);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad("timeout");
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (exp_q[i]) rd(8'h10 + 8'(4 * i), exp_q[i]);
        chk_bit(pin1 | pin2 | oe1, 1'b0);
        rd(8'h40, 8'h00);
        chk_bit(rerr, 1'b1);
        for (int ch = 0; ch < 2; ch++) begin
            seed = lfsr(seed);
            apb(1'b1, 8'h10 + 8'(8 * ch), seed[15:8] | 8'h80);
            apb(1'b1, 8'h14 + 8'(8 * ch), seed[7:0]);
            rd(8'h10 + 8'(8 * ch), seed[15:8] | 8'h80);
            rd(8'h14 + 8'(8 * ch), seed[7:0]);
        end
        $display("test registers done");
        // Each clock source, pin enabled on odd codes only.
        for (int k = 0; k < 4; k++) begin
            logic lvl;
            lvl = ~exp_pin;
            ext_on <= (k == 3);
            apb(1'b1, `TOCP_OFS_CTRL_ONE, {7'h20, lvl});
            apb(1'b1, `TOCP_OFS_CTRL_TWO, {k[0], 3'h0, k[1:0], 2'h1});
            apb(1'b1, `TOCP_OFS_CMP1_HI, 8'h00);
            apb(1'b1, `TOCP_OFS_CMP1_LO, 8'h04);
            apb(1'b1, `TOCP_OFS_COUNT, 8'h00);
            wt(1'b1, 1'b1, 300);
            chk_bit(pin1, k[0] ? lvl : exp_pin);
            if (k[0])
                exp_pin = lvl;
            mask <= 1'b1;
            @(posedge clk);
            chk_bit(irq, 1'b0);
            mask <= 1'b0;
            repeat (10) @(posedge clk);
            rd(`TOCP_OFS_CMP1_LO, 8'h04);
            rd(`TOCP_OFS_STATUS, 8'h40, 8'h40);
            rd(`TOCP_OFS_CMP1_LO, 8'h04);
            rd(`TOCP_OFS_STATUS, 8'h00, 8'h40);
            chk_bit(irq, 1'b0);
        end
        ext_on <= 1'b0;
        $display("test compare clocks done");
        apb(1'b1, `TOCP_OFS_CTRL_TWO, 8'h04);
        apb(1'b1, `TOCP_OFS_CMP1_HI, 8'h00);
        apb(1'b1, `TOCP_OFS_COUNT, 8'h00);
        repeat (60) @(posedge clk);
        chk_bit(irq, 1'b0);
        apb(1'b1, `TOCP_OFS_CMP1_LO, 8'h30);
        wt(1'b1, 1'b1, 200);
        rd(`TOCP_OFS_STATUS, 8'h40, 8'h40);
        rd(`TOCP_OFS_CMP1_LO, 8'h30);
        $display("test suspend done");
        apb(1'b1, `TOCP_OFS_CTRL_TWO, 8'h84);
        apb(1'b1, `TOCP_OFS_CTRL_ONE, {7'h04, ~exp_pin});
        wt(1'b0, ~exp_pin, 8);
        apb(1'b1, `TOCP_OFS_CTRL_ONE, {7'h04, exp_pin});
        wt(1'b0, exp_pin, 8);
        rd(`TOCP_OFS_STATUS, 8'h00, 8'h40);
        $display("test force done");
        apb(1'b1, `TOCP_OFS_CMP1_LO, 8'h10);
        apb(1'b1, `TOCP_OFS_CTRL_ONE, 8'h86);
        apb(1'b1, `TOCP_OFS_CTRL_TWO, 8'hA4);
        fire <= 1'b1;
        wt(1'b0, 1'b1, 20);
        rd(`TOCP_OFS_STATUS, 8'h80, 8'hC0);
        chk_bit(irq, 1'b1);
        rd(`TOCP_OFS_CAP1_HI, 8'hFF);
        rd(`TOCP_OFS_CAP1_LO, 8'hFD);
        wt(1'b0, 1'b0, 200);
        rd(`TOCP_OFS_STATUS, 8'h00, 8'hC0);
        apb(1'b1, `TOCP_OFS_CTRL_ONE, 8'h8F);
        repeat (6) @(posedge clk);
        chk_bit(pin1, 1'b0);
        $display("test one pulse done");
        fire <= 1'b0;
        apb(1'b1, `TOCP_OFS_COUNT, 8'h00);
        apb(1'b1, `TOCP_OFS_CTRL_ONE, 8'h81);
        apb(1'b1, `TOCP_OFS_CMP1_LO, 8'h08);
        apb(1'b1, `TOCP_OFS_CMP2_HI, 8'h00);
        apb(1'b1, `TOCP_OFS_CMP2_LO, 8'h20);
        apb(1'b1, `TOCP_OFS_CTRL_TWO, 8'hF4);
        apb(1'b1, `TOCP_OFS_COUNT, 8'h00);
        wt(1'b0, 1'b1, 100);
        wt(1'b0, 1'b0, 200);
        wt(1'b0, 1'b1, 200);
        rd(`TOCP_OFS_STATUS, 8'h80, 8'hE0);
        chk_bit(oe2, 1'b0);
        $display("test pwm done");
        test_done;
    end
endmodule // test_timer_output_compare_pwm
